// ==== design/delay_meter.sv ====
// per-bridge measurement of turn-on and turn-off switching times
`timescale 1ns/1ns
module delay_meter
  import hb_pwm_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_start_on,
  input  wire logic        i_start_off,
  input  wire logic        i_sw_end,
  input  wire logic        i_short,
  input  wire logic [7:0]  i_blank,
  input  wire logic [7:0]  i_ccp_act,
  output logic      [15:0] o_delay
);

  typedef struct packed {
    logic       on_run;
    logic [7:0] on_cnt;
    logic       off_run;
    logic [7:0] off_cnt;
    logic [7:0] d_on;
    logic [7:0] d_off;
  } meter_t;

  meter_t s;
  meter_t next_s;

  always_comb
  begin
    next_s = s;
    // turn-on: count until the switch reports its transition done
    if (i_start_on)
    begin
      next_s.on_run = 1'b1;
      next_s.on_cnt = 8'h00;
    end
    else if (s.on_run)
    begin
      if (i_sw_end)
      begin
        next_s.d_on   = s.on_cnt;
        next_s.on_run = 1'b0;
      end
      else if (s.on_cnt >= i_blank)
      begin
        next_s.d_on   = 8'h00;
        next_s.on_run = 1'b0;
      end
      else
        next_s.on_cnt = s.on_cnt + 8'h01;
    end
    // turn-off: bounded by the active cross-conduction time
    if (i_start_off)
    begin
      next_s.off_run = 1'b1;
      next_s.off_cnt = 8'h00;
    end
    else if (s.off_run)
    begin
      if (i_sw_end)
      begin
        next_s.d_off   = s.off_cnt;
        next_s.off_run = 1'b0;
      end
      else if (s.off_cnt >= i_ccp_act)
      begin
        next_s.d_off   = 8'h00;
        next_s.off_run = 1'b0;
      end
      else
        next_s.off_cnt = s.off_cnt + 8'h01;
    end
    // duty too extreme to tell edges apart: nothing is trustworthy
    if (i_short)
    begin
      next_s.on_run  = 1'b0;
      next_s.off_run = 1'b0;
      next_s.d_on    = 8'h00;
      next_s.d_off   = 8'h00;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_delay = {s.d_off, s.d_on};

endmodule

// ==== design/hb_pwm_ctrl.sv ====
// top: avalon register slave and gate command logic for three half-bridges
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
module hb_pwm_ctrl
  import hb_pwm_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic [4:0]  I_ADDRESS,
  input  wire logic        I_READ,
  input  wire logic        I_WRITE,
  input  wire logic [31:0] I_WRITEDATA,
  input  wire logic [3:0]  I_BYTEENABLE,
  output logic      [31:0] O_READDATA,
  output logic             O_WAITREQUEST,
  input  wire logic [5:0]  I_PWM,
  input  wire logic [2:0]  I_ROLE_HS_ACTIVE,
  input  wire logic [2:0]  I_HS_SW_END,
  input  wire logic [2:0]  I_LS_SW_END,
  output logic      [2:0]  O_HS_ON,
  output logic      [2:0]  O_LS_ON,
  output logic      [2:0]  O_HS_HOLD_OFF,
  output logic      [2:0]  O_LS_HOLD_OFF,
  output logic      [5:0]  O_PRECHG_PART,
  output logic      [5:0]  O_PREDCHG_PART
);

  typedef struct packed {
    logic       hs;
    logic       ls;
    logic       hold_hs;
    logic       hold_ls;
    logic       p_prev;
    logic       act_prev;
    logic       short;
    logic [7:0] since_off;
    logic [7:0] hi_cnt;
    logic [7:0] lo_cnt;
    logic       pc_run;
    logic [7:0] pc_cnt;
    logic [1:0] pc_part;
    logic       pd_run;
    logic [7:0] pd_cnt;
    logic [1:0] pd_part;
  } bridge_t;

  typedef struct packed {
    logic              ack;
    logic [31:0]       rdata;
    logic [8:0]        ctrl;
    logic [5:0]        mode;
    logic [23:0]       timing;
    logic [31:0]       phase;
    bridge_t [NB-1:0]  br;
  } top_t;

  top_t s;
  top_t next_s;

  logic [5:0]        pwm_s;
  logic [NB-1:0]     act_rise;
  logic [NB-1:0]     act_fall;
  logic [NB-1:0]     sw_end;
  logic [15:0]       dly [NB];

  // saturating increment, so idle counters never wrap to a small value
  function automatic logic [7:0] sat_inc(input logic [7:0] x);
    sat_inc = (x == 8'hFF) ? x : x + 8'h01;
  endfunction

  // byte-lane merge for avalon writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = wd[8*i +: 8];
    merge = r;
  endfunction

  pwm_sync u_sync (
    .i_clk (I_CLK),
    .i_rst (I_RST),
    .i_pwm (I_PWM),
    .o_pwm (pwm_s)
  );

  // one meter per bridge, watching the active mosfet's transitions
  for (genvar g = 0; g < NB; g++)
  begin : g_meter
    delay_meter u_meter (
      .i_clk       (I_CLK),
      .i_rst       (I_RST),
      .i_start_on  (act_rise[g]),
      .i_start_off (act_fall[g]),
      .i_sw_end    (sw_end[g]),
      .i_short     (s.br[g].short),
      .i_blank     (s.timing[TIM_BLANK +: 8]),
      .i_ccp_act   (s.timing[TIM_CCP_ACT +: 8]),
      .o_delay     (dly[g])
    );
  end

  always_comb
  begin
    logic        req;
    logic        six;
    logic        en;
    logic        afw;
    logic        p;
    logic        phs;
    logic        pls;
    logic        pwm_hs;
    logic        hs_act;
    logic        hs_req;
    logic        ls_req;
    logic        act_on;
    logic [7:0]  ccp_act;
    logic [7:0]  ccp_fw;
    logic [7:0]  need_hs;
    logic [7:0]  need_ls;
    logic [31:0] rd;
    drive_mode_t md;
    req      = I_READ | I_WRITE;
    six      = s.ctrl[CTRL_CNT_SEL];
    ccp_act  = s.timing[TIM_CCP_ACT +: 8];
    ccp_fw   = s.timing[TIM_CCP_FW +: 8];
    next_s   = s;
    act_rise = '0;
    act_fall = '0;
    sw_end   = '0;
    {en, afw, p, phs, pls, pwm_hs, hs_act, hs_req, ls_req, act_on} = '0;
    {need_hs, need_ls} = '0;
    rd       = 32'h00000000;
    md       = MODE_OFF_PASSIVE;

    // bus slave: one wait cycle, then the answer stands for one cycle
    next_s.ack = req & ~s.ack;
    unique case (I_ADDRESS & 5'h1C)
      OFS_CTRL:   rd = {23'h000000, s.ctrl};
      OFS_MODE:   rd = {26'h0000000, s.mode};
      OFS_TIMING: rd = {8'h00, s.timing};
      OFS_PHASE:  rd = s.phase;
      OFS_STATUS: rd = {23'h000000, s.br[2].short, s.br[1].short, s.br[0].short,
                        O_LS_ON, O_HS_ON};
      OFS_DLY1:   rd = {16'h0000, dly[0]};
      OFS_DLY2:   rd = {16'h0000, dly[1]};
      OFS_DLY3:   rd = {16'h0000, dly[2]};
      default:    rd = 32'h00000000;
    endcase
    if (req & ~s.ack)
      next_s.rdata = I_READ ? rd : 32'h00000000;

    // writes land on the edge where waitrequest is seen low
    if (I_WRITE & s.ack)
    begin
      unique case (I_ADDRESS & 5'h1C)
        OFS_CTRL:   next_s.ctrl   = 9'(merge({23'h000000, s.ctrl}, I_WRITEDATA,
                                             I_BYTEENABLE));
        OFS_MODE:   next_s.mode   = 6'(merge({26'h0000000, s.mode}, I_WRITEDATA,
                                             I_BYTEENABLE));
        OFS_TIMING: next_s.timing = 24'(merge({8'h00, s.timing}, I_WRITEDATA,
                                              I_BYTEENABLE));
        OFS_PHASE:  next_s.phase  = merge(s.phase, I_WRITEDATA, I_BYTEENABLE);
        default:    next_s.rdata  = s.rdata;
      endcase
    end

    for (int b = 0; b < NB; b++)
    begin
      md  = drive_mode_t'(s.mode[2*b +: 2]);
      en  = s.ctrl[CTRL_PEN + b] & ((md == MODE_LS_PWM) | (md == MODE_HS_PWM));
      afw = s.ctrl[CTRL_AFW + b];
      phs = pwm_s[2*b];      // inputs 1,3,5: single input or high side
      pls = pwm_s[2*b + 1];  // inputs 2,4,6: low side in six-input use
      pwm_hs = (md == MODE_HS_PWM);
      p = (six & ~pwm_hs) ? pls : phs;

      // very short pulses: remember whether the last on or off was too brief
      next_s.br[b].p_prev = p;
      if (p)
        next_s.br[b].hi_cnt = s.br[b].p_prev ? sat_inc(s.br[b].hi_cnt) : 8'h01;
      else
        next_s.br[b].lo_cnt = s.br[b].p_prev ? 8'h01 : sat_inc(s.br[b].lo_cnt);
      if (p & ~s.br[b].p_prev)
        next_s.br[b].short = s.br[b].lo_cnt < ccp_act;
      else if (~p & s.br[b].p_prev)
        next_s.br[b].short = s.br[b].hi_cnt < ccp_fw;
      if (~en)
        next_s.br[b].short = 1'b0;

      // role of the mosfets: detected, or fixed by the mode
      if (s.br[b].short)
        hs_act = pwm_hs;
      else if (s.ctrl[CTRL_ROLE])
        hs_act = I_ROLE_HS_ACTIVE[b];
      else
        hs_act = pwm_hs;

      // requested gate states per input arrangement
      if (s.br[b].short)
      begin
        hs_req = pwm_hs & p;
        ls_req = ~pwm_hs & p;
      end
      else if (six)
      begin
        hs_req = phs & ~pls;
        ls_req = pls & ~phs;
      end
      else
      begin
        hs_req = pwm_hs ? p : (afw & ~p);
        ls_req = pwm_hs ? (afw & ~p) : p;
      end

      // dead time: active turn-on waits freewheel time, freewheel waits active
      need_hs = hs_act ? ccp_fw : ccp_act;
      need_ls = hs_act ? ccp_act : ccp_fw;
      next_s.br[b].hs = en & hs_req & ~s.br[b].ls &
                        (s.br[b].hs | (s.br[b].since_off >= need_hs));
      next_s.br[b].ls = en & ls_req & ~s.br[b].hs &
                        (s.br[b].ls | (s.br[b].since_off >= need_ls));
      next_s.br[b].since_off = (s.br[b].hs | s.br[b].ls) ? 8'h00 :
                               sat_inc(s.br[b].since_off);

      // off modes win over enable; passive discharge unless mode 11
      next_s.br[b].hold_hs = (md == MODE_OFF_ACTIVE) |
                             (en & ~next_s.br[b].hs & ~(s.br[b].short & ~pwm_hs));
      next_s.br[b].hold_ls = (md == MODE_OFF_ACTIVE) |
                             (en & ~next_s.br[b].ls & ~(s.br[b].short & pwm_hs));
      if (md == MODE_OFF_PASSIVE)
      begin
        next_s.br[b].hold_hs = 1'b0;
        next_s.br[b].hold_ls = 1'b0;
      end

      // edges of the active mosfet start the adaptive phases and the meter
      act_on = hs_act ? next_s.br[b].hs : next_s.br[b].ls;
      next_s.br[b].act_prev = act_on;
      act_rise[b] = act_on & ~s.br[b].act_prev;
      act_fall[b] = ~act_on & s.br[b].act_prev;
      sw_end[b]   = hs_act ? I_HS_SW_END[b] : I_LS_SW_END[b];

      // pre-charge phase timer
      if (act_rise[b])
      begin
        next_s.br[b].pc_run = s.phase[PH_PC_DUR +: 8] != 8'h00;
        next_s.br[b].pc_cnt = 8'h00;
      end
      else if (s.br[b].pc_run)
      begin
        next_s.br[b].pc_cnt = s.br[b].pc_cnt + 8'h01;
        next_s.br[b].pc_run = (s.br[b].pc_cnt + 8'h01) < s.phase[PH_PC_DUR +: 8];
      end
      // pre-discharge phase timer
      if (act_fall[b])
      begin
        next_s.br[b].pd_run = s.phase[PH_PD_DUR +: 8] != 8'h00;
        next_s.br[b].pd_cnt = 8'h00;
      end
      else if (s.br[b].pd_run)
      begin
        next_s.br[b].pd_cnt = s.br[b].pd_cnt + 8'h01;
        next_s.br[b].pd_run = (s.br[b].pd_cnt + 8'h01) < s.phase[PH_PD_DUR +: 8];
      end

      // current part: single part unless split, then switch at first length
      if (~next_s.br[b].pc_run)
        next_s.br[b].pc_part = PART_NONE;
      else if (s.ctrl[CTRL_SPLIT] & (next_s.br[b].pc_cnt >= s.phase[PH_PC_FIRST +: 8]))
        next_s.br[b].pc_part = PART_TWO;
      else
        next_s.br[b].pc_part = PART_ONE;
      if (~next_s.br[b].pd_run)
        next_s.br[b].pd_part = PART_NONE;
      else if (s.ctrl[CTRL_SPLIT] & (next_s.br[b].pd_cnt >= s.phase[PH_PD_FIRST +: 8]))
        next_s.br[b].pd_part = PART_TWO;
      else
        next_s.br[b].pd_part = PART_ONE;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      s        <= '0;
      s.ctrl   <= RST_CTRL;
      s.mode   <= RST_MODE;
      s.timing <= RST_TIMING;
      s.phase  <= RST_PHASE;
      for (int b = 0; b < NB; b++)
      begin
        s.br[b].since_off <= RST_CNT;
        s.br[b].hi_cnt    <= RST_CNT;
        s.br[b].lo_cnt    <= RST_CNT;
      end
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register
  assign O_READDATA    = s.rdata;
  assign O_WAITREQUEST = ~s.ack;
  for (genvar g = 0; g < NB; g++)
  begin : g_out
    assign O_HS_ON[g]               = s.br[g].hs;
    assign O_LS_ON[g]               = s.br[g].ls;
    assign O_HS_HOLD_OFF[g]         = s.br[g].hold_hs;
    assign O_LS_HOLD_OFF[g]         = s.br[g].hold_ls;
    assign O_PRECHG_PART[2*g +: 2]  = s.br[g].pc_part;
    assign O_PREDCHG_PART[2*g +: 2] = s.br[g].pd_part;
  end

endmodule

// ==== design/hb_pwm_pkg.sv ====
// package: register map, field positions and reset values of the half-bridge pwm control
package hb_pwm_pkg;

  localparam int NB = 3;

  // byte offsets on the register bus
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_MODE   = 5'h04;
  localparam logic [4:0] OFS_TIMING = 5'h08;
  localparam logic [4:0] OFS_PHASE  = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_DLY1   = 5'h14;
  localparam logic [4:0] OFS_DLY2   = 5'h18;
  localparam logic [4:0] OFS_DLY3   = 5'h1C;

  // control register fields
  localparam int CTRL_CNT_SEL = 0;
  localparam int CTRL_ROLE    = 1;
  localparam int CTRL_SPLIT   = 2;
  localparam int CTRL_PEN     = 3;
  localparam int CTRL_AFW     = 6;

  // timing and phase register fields, all 8 bits wide
  localparam int TIM_CCP_ACT = 0;
  localparam int TIM_CCP_FW  = 8;
  localparam int TIM_BLANK   = 16;
  localparam int PH_PC_DUR   = 0;
  localparam int PH_PD_DUR   = 8;
  localparam int PH_PC_FIRST = 16;
  localparam int PH_PD_FIRST = 24;

  // values after reset
  localparam logic [8:0]  RST_CTRL   = 9'h000;
  localparam logic [5:0]  RST_MODE   = 6'h00;
  localparam logic [23:0] RST_TIMING = 24'h28_0A_0A;
  localparam logic [31:0] RST_PHASE  = 32'h04_04_08_08;
  localparam logic [7:0]  RST_CNT    = 8'hFF;

  // current part driven during a pre-charge or pre-discharge phase
  localparam logic [1:0] PART_NONE = 2'h0;
  localparam logic [1:0] PART_ONE  = 2'h1;
  localparam logic [1:0] PART_TWO  = 2'h2;

  typedef enum logic [1:0] {
    MODE_OFF_PASSIVE = 2'b00,
    MODE_LS_PWM      = 2'b01,
    MODE_HS_PWM      = 2'b10,
    MODE_OFF_ACTIVE  = 2'b11
  } drive_mode_t;

endpackage

// ==== design/pwm_sync.sv ====
// two-stage synchroniser for the external pwm inputs
`timescale 1ns/1ns
module pwm_sync
  import hb_pwm_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [5:0] i_pwm,
  output logic      [5:0] o_pwm
);

  typedef struct packed {
    logic [5:0] stage1;
    logic [5:0] stage2;
  } sync_t;

  sync_t s;
  sync_t next_s;

  // stage1 feeds stage2 only, so no logic sees a metastable level
  always_comb
  begin
    next_s        = s;
    next_s.stage1 = i_pwm;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign o_pwm = s.stage2;

endmodule

// ==== tb/hb_pwm_chk.sv ====
// checker of the half-bridge pwm control top-level ports
`timescale 1ns/1ns
module hb_pwm_chk
  import hb_pwm_pkg::*;
(
  input wire logic       I_CLK,
  input wire logic       I_RST,
  input wire logic       I_READ,
  input wire logic       I_WRITE,
  input wire logic       O_WAITREQUEST,
  input wire logic [2:0] O_HS_ON,
  input wire logic [2:0] O_LS_ON,
  input wire logic [2:0] O_HS_HOLD_OFF,
  input wire logic [2:0] O_LS_HOLD_OFF,
  input wire logic [5:0] O_PRECHG_PART,
  input wire logic [5:0] O_PREDCHG_PART
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // bus answer: one wait cycle, one answer cycle, never unasked
  ack_once_a:
    assert property ($rose(I_READ || I_WRITE) |=> !O_WAITREQUEST ##1 O_WAITREQUEST)
    else $error("waitrequest answer not exactly one cycle");
  ack_cause_a:
    assert property (!O_WAITREQUEST |-> $past(I_READ || I_WRITE))
    else $error("waitrequest low without request");
  // no shoot-through, and a switch on is never held off
  no_shoot_a:
    assert property ((O_HS_ON & O_LS_ON) == 3'h0)
    else $error("both switches of a bridge on");
  on_free_a:
    assert property (((O_HS_ON & O_HS_HOLD_OFF) | (O_LS_ON & O_LS_HOLD_OFF)) == 3'h0)
    else $error("switch on while held off");
  // turn-on only after the opposite switch was off for two cycles
  hs_wait_a:
    assert property ($rose(O_HS_ON[0]) |-> !$past(O_LS_ON[0], 1) && !$past(O_LS_ON[0], 2))
    else $error("high side on without dead time");
  ls_wait_a:
    assert property ($rose(O_LS_ON[0]) |-> !$past(O_HS_ON[0], 1) && !$past(O_HS_ON[0], 2))
    else $error("low side on without dead time");
  // current parts: legal codes, second part only after the first
  part_legal_a:
    assert property (O_PRECHG_PART[1:0] != 2'h3 && O_PREDCHG_PART[1:0] != 2'h3)
    else $error("illegal current part code");
  pc_order_a:
    assert property ($rose(O_PRECHG_PART[1]) |-> $past(O_PRECHG_PART[1:0]) == PART_ONE)
    else $error("pre-charge second part without first");
  pd_order_a:
    assert property ($rose(O_PREDCHG_PART[1]) |-> $past(O_PREDCHG_PART[1:0]) == PART_ONE)
    else $error("pre-discharge second part without first");
endmodule
bind hb_pwm_ctrl hb_pwm_chk chk_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_READ(I_READ),
  .I_WRITE(I_WRITE), .O_WAITREQUEST(O_WAITREQUEST), .O_HS_ON(O_HS_ON), .O_LS_ON(O_LS_ON),
  .O_HS_HOLD_OFF(O_HS_HOLD_OFF), .O_LS_HOLD_OFF(O_LS_HOLD_OFF),
  .O_PRECHG_PART(O_PRECHG_PART), .O_PREDCHG_PART(O_PREDCHG_PART));

// ==== tb/hb_pwm_ctrl_bench.sv ====
// bench of the half-bridge pwm control: registers, gate commands, measurements
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module hb_pwm_ctrl_bench
  import hb_pwm_pkg::*;
;
  typedef struct packed {
    logic [8:0] ctrl;
    logic [5:0] mode;
    logic [5:0] pwm;
    logic [3:0] ex;
  } row_t;
  row_t        rows [14];
  logic [31:0] rst_val [4];
  logic [31:0] msk [4];
  logic [11:0] exp_g;
  logic        clk, rst, rd, wr, wreq, seen_pc, seen_pd, clr;
  logic [4:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [5:0]  want, pwm, pre, pdc;
  logic [2:0]  role, hs_end, ls_end, hs, ls, hh, lh;
  int          error_cnt, checks, cyc;

  hb_pwm_ctrl dut_u (.I_CLK(clk), .I_RST(rst), .I_ADDRESS(adr), .I_READ(rd), .I_WRITE(wr),
    .I_WRITEDATA(wdat), .I_BYTEENABLE(4'hF), .O_READDATA(rdat), .O_WAITREQUEST(wreq),
    .I_PWM(pwm), .I_ROLE_HS_ACTIVE(role), .I_HS_SW_END(hs_end), .I_LS_SW_END(ls_end),
    .O_HS_ON(hs), .O_LS_ON(ls), .O_HS_HOLD_OFF(hh), .O_LS_HOLD_OFF(lh),
    .O_PRECHG_PART(pre), .O_PREDCHG_PART(pdc));
  pwm_host host_u (.i_clk(clk), .i_want(want), .o_pwm(pwm));

  always #10 clk = ~clk;

  // sticky flags: a second current part was seen on bridge 1; clr keeps them low
  always @(posedge clk)
  begin
    seen_pc <= !clr && (seen_pc || pre[1:0] === PART_TWO);
    seen_pd <= !clr && (seen_pd || pdc[1:0] === PART_TWO);
  end

  // hang guard, far above the little over a thousand cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wait_hs(input logic v);
    for (int k = 0; k < 200 && hs[0] !== v; k++) @(posedge clk);
  endtask

  // one long pwm period; switch-end feedback on turn-on and/or turn-off
  // the low side reports the opposite, so measuring the wrong switch shows up
  task automatic pulse(input logic e_on, input logic e_off);
    want <= 6'h15;
    wait_hs(1'b1);
    repeat (5) @(posedge clk);
    hs_end <= {3{e_on}};
    ls_end <= {3{~e_on}};
    repeat (50) @(posedge clk);
    want   <= 6'h00;
    hs_end <= 3'h0;
    ls_end <= 3'h0;
    wait_hs(1'b0);
    repeat (3) @(posedge clk);
    hs_end <= {3{e_off}};
    ls_end <= {3{~e_off}};
    repeat (60) @(posedge clk);
    hs_end <= 3'h0;
    ls_end <= 3'h0;
    bus(1'b0, OFS_DLY1, 32'h0);
  endtask

  initial
  begin
    {clk, rd, wr, adr, wdat, want, hs_end, ls_end} = '0;
    rst = 1'b1;
    clr = 1'b1;
    role = 3'h7;
    {error_cnt, checks, cyc} = '0;
    rst_val = '{{23'h0, RST_CTRL}, {26'h0, RST_MODE}, {8'h0, RST_TIMING}, RST_PHASE};
    msk = '{32'h0000_01FF, 32'h0000_003F, 32'h00FF_FFFF, 32'hFFFF_FFFF};
    rows = '{'{9'h038, 6'h00, 6'h15, 4'h0}, '{9'h038, 6'h3F, 6'h15, 4'h3},
             '{9'h1F8, 6'h2A, 6'h15, 4'h9}, '{9'h1F8, 6'h2A, 6'h00, 4'h6},
             '{9'h038, 6'h15, 6'h15, 4'h6}, '{9'h038, 6'h15, 6'h00, 4'h3},
             '{9'h039, 6'h2A, 6'h15, 4'h9}, '{9'h039, 6'h2A, 6'h2A, 4'h6},
             '{9'h039, 6'h2A, 6'h3F, 4'h3}, '{9'h039, 6'h15, 6'h00, 4'h3},
             '{9'h000, 6'h2A, 6'h15, 4'h0}, '{9'h03B, 6'h15, 6'h15, 4'h9},
             '{9'h039, 6'h00, 6'h15, 4'h0}, '{9'h039, 6'h3F, 6'h2A, 4'h3}};
    repeat (2) @(posedge clk);
    `CHK("wait_in_reset", 1'b1, wreq)
    `CHK("gates_in_reset", 12'h000, {hs, ls, hh, lh})
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b0, 5'(i * 4), 32'h0);
      `CHK("reset_value", rst_val[i], q)
      // every writable bit sticks, reserved bits read zero; then back to reset value
      bus(1'b1, 5'(i * 4), 32'hFFFF_FFFF);
      bus(1'b0, 5'(i * 4), 32'h0);
      `CHK("reg_width", msk[i], q)
      bus(1'b1, 5'(i * 4), rst_val[i]);
    end
    bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("status_ro", 32'h0, q)
    // mode table: settle past the dead time, then compare every bridge
    foreach (rows[i])
    begin
      bus(1'b1, OFS_CTRL, {23'h0, rows[i].ctrl});
      bus(1'b1, OFS_MODE, {26'h0, rows[i].mode});
      want <= rows[i].pwm;
      repeat (40) @(posedge clk);
      exp_g = {{3{rows[i].ex[3]}}, {3{rows[i].ex[2]}}, {3{rows[i].ex[1]}}, {3{rows[i].ex[0]}}};
      `CHK("gates", exp_g, {hs, ls, hh, lh})
    end
    bus(1'b1, OFS_CTRL, 32'h1F8);
    bus(1'b1, OFS_MODE, 32'h2A);
    want <= 6'h00;
    repeat (40) @(posedge clk);
    clr <= 1'b0;
    pulse(1'b1, 1'b0);
    `CHK("on_delay_seen", 1'b1, q[7:0] != 8'h00)
    `CHK("off_delay_missed", 8'h00, q[15:8])
    pulse(1'b0, 1'b1);
    `CHK("on_delay_missed", 8'h00, q[7:0])
    `CHK("off_delay_seen", 1'b1, q[15:8] != 8'h00)
    `CHK("single_part", 2'b00, {seen_pc, seen_pd})
    // both ends reported, so the short case below must clear real values
    bus(1'b1, OFS_CTRL, 32'h1FC);
    pulse(1'b1, 1'b1);
    `CHK("split_parts", 2'b11, {seen_pc, seen_pd})
    // on-time well below the freewheel dead time
    want <= 6'h15;
    repeat (3) @(posedge clk);
    want <= 6'h00;
    repeat (30) @(posedge clk);
    `CHK("short_opposite", 2'b00, {ls[0], lh[0]})
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("short_flag", 1'b1, q[6])
    bus(1'b0, OFS_DLY1, 32'h0);
    `CHK("short_zero", 16'h0000, q[15:0])
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl_rereset", 32'h0, q)
    tally_and_finish;
  end
endmodule

// ==== tb/pwm_host.sv ====
// host model: drives the six pwm pins and keeps every level for two clocks
`timescale 1ns/1ns
module pwm_host
(
  input  wire logic       i_clk,
  input  wire logic [5:0] i_want,
  output logic      [5:0] o_pwm
);
  logic [1:0] held;
  initial o_pwm = 6'h00;
  initial held = 2'h0;
  // a new level waits until the old one stood two clocks, else the synchroniser may miss it
  always @(posedge i_clk)
  begin
    if (held >= 2'h1 && i_want != o_pwm)
    begin
      o_pwm <= i_want;
      held  <= 2'h0;
    end
    else if (held != 2'h3)
      held <= held + 2'h1;
  end
endmodule
